// File: dsm_pkg.sv
// constants, states and field layout of the drive state machine
//
// Behaviour
// RULE1 - master steers via command word, reads status word
// RULE2 - initialising: motor off, parameter writes refused
// RULE3 - idle states: motor off, parameter writes accepted
// RULE4 - enabled, quick stop, reaction: motor energised
// RULE5 - fault with alarm: motor off, writes accepted
// RULE6 - 250 ms preparation gates motion, then ready
// RULE7 - master waits 250 ms or ready before motion
// RULE8 - decode shutdown, switch on, disable, quick stop, reset
// RULE9 - 1111 enables operation; 0111 disables operation
// RULE10 - switch on needs network, power, release, torque, test
// RULE11 - power-up enters not-ready-to-switch-on
// RULE12 - init done advances to switch-on-disabled
// RULE13 - quick stop option 1..3: stop, then disabled
// RULE14 - any alarm: fault reaction, then fault
// RULE15 - switched on, stopped, drop condition: ready
// RULE16 - enabled, stopped, drop condition: ready, motor off
// RULE17 - status word low bits encode state
// RULE18 - network lost while moving: alarm 81h, fault
// RULE19 - unmatched command leaves state unchanged
// RULE20 - fault reset edge, alarm gone: switch-on-disabled
`default_nettype none
package dsm_pkg;
	// object indices
	localparam logic [15:0] DSM_CMD_WORD_IDX = 16'h6040;
	localparam logic [15:0] DSM_STATUS_WORD_IDX = 16'h6041;
	localparam logic [15:0] DSM_CMD_WORD_RST = 16'h0000;
	localparam logic [15:0] DSM_STATUS_WORD_RST = 16'h0000;
	// command word fields
	localparam int DSM_CW_FAULT_RESET = 7;
	localparam logic [3:0] DSM_CW_SWITCH_ON = 4'h7;
	localparam logic [3:0] DSM_CW_ENABLE_OP = 4'hF;
	// status word fields
	localparam int DSM_SW_READY = 0;
	localparam int DSM_SW_SWITCHED_ON = 1;
	localparam int DSM_SW_OP_ENABLED = 2;
	localparam int DSM_SW_FAULT = 3;
	localparam int DSM_SW_VOLTAGE = 4;
	localparam int DSM_SW_QUICK_STOP = 5;
	localparam int DSM_SW_ON_DISABLED = 6;
	// alarm code and quick stop option range
	localparam logic [7:0] DSM_NET_ALARM_CODE = 8'h81;
	localparam logic [7:0] DSM_NO_ALARM_CODE = 8'h00;
	localparam logic signed [15:0] DSM_QSO_MIN = 16'sh0001;
	localparam logic signed [15:0] DSM_QSO_MAX = 16'sh0003;
	// preparation time after entering operation enabled
	localparam int DSM_PREP_TIME_MS = 250;
	localparam int DSM_CLK_KHZ = 10_000;
	localparam int DSM_PREP_CYCLES = DSM_PREP_TIME_MS * DSM_CLK_KHZ;
	localparam int DSM_PREP_CNT_W = 22;
	// drive states, one-hot
	typedef enum logic [7:0] {
		DSM_NOT_READY = 8'h01,
		DSM_ON_DISABLED = 8'h02,
		DSM_READY = 8'h04,
		DSM_SWITCHED_ON = 8'h08,
		DSM_OP_ENABLED = 8'h10,
		DSM_QUICK_STOP = 8'h20,
		DSM_FAULT_REACT = 8'h40,
		DSM_FAULT = 8'h80
	} dsm_state_t;
endpackage
`default_nettype wire

// File: dsm_cmd_decode.sv
// command word decoder with fault reset edge detection
`default_nettype none
module dsm_cmd_decode
	import dsm_pkg::*;
(
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// stored command word
	input wire logic [15:0] cmd_word,
	// decoded commands
	output logic cmd_shutdown,
	output logic cmd_switch_on,
	output logic cmd_enable_op,
	output logic cmd_disable_voltage,
	output logic cmd_quick_stop,
	output logic fault_reset_pulse
);
	typedef struct packed {
		logic reset_bit;
	} dsm_dec_regs_t;

	dsm_dec_regs_t q, d;

	// patterns are mutually exclusive by construction
	assign cmd_disable_voltage = !cmd_word[1]; // [RULE8]
	assign cmd_quick_stop = cmd_word[1] && !cmd_word[2]; // [RULE8]
	assign cmd_shutdown = cmd_word[2:0] == 3'h6; // [RULE8]
	assign cmd_switch_on = cmd_word[3:0] == DSM_CW_SWITCH_ON; // [RULE9]
	assign cmd_enable_op = cmd_word[3:0] == DSM_CW_ENABLE_OP; // [RULE9]
	// only a rising edge counts, a held bit resets once
	assign fault_reset_pulse = ce && cmd_word[DSM_CW_FAULT_RESET]
		&& !q.reset_bit; // [RULE8]

	// remember last fault reset bit
	always_comb begin
		d = q;
		d.reset_bit = cmd_word[DSM_CW_FAULT_RESET];
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	reset_edge_a: assert property ( // [RULE8]
		fault_reset_pulse |=> !fault_reset_pulse)
		else $error("fault reset pulse held longer than one cycle");
endmodule
`default_nettype wire

// File: dsm_prep_timer.sv
// preparation timer for operation enabled
`default_nettype none
module dsm_prep_timer
	import dsm_pkg::*;
#(
	parameter int unsigned CYCLES = DSM_PREP_CYCLES
) (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// timing
	input wire logic run,
	output logic done
);
	localparam logic [DSM_PREP_CNT_W-1:0] LAST =
		DSM_PREP_CNT_W'(CYCLES - 1);

	typedef struct packed {
		logic [DSM_PREP_CNT_W-1:0] cnt;
		logic done;
	} dsm_tmr_regs_t;

	dsm_tmr_regs_t q, d;

	assign done = q.done;

	// counts from entry, clears as soon as run drops
	always_comb begin
		d = q;
		if (!run) begin
			d.cnt = '0;
			d.done = 1'b0;
		end else if (!q.done) begin
			d.cnt = q.cnt + 1'b1;
			d.done = q.cnt == LAST; // [RULE6]
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	done_cause_a: assert property ( // [RULE6]
		$rose(done) |-> $past(run) && $past(q.cnt) == LAST)
		else $error("ready rose before the full preparation count");
	run_drop_a: assert property ( // [RULE6]
		ce && !run |=> !done)
		else $error("ready stayed up after leaving operation");
endmodule
`default_nettype wire

// File: dsm_top.sv
// drive state machine: command word, status word, motor enable
`default_nettype none
module dsm_top
	import dsm_pkg::*;
#(
	parameter int unsigned PREP_CYCLES = DSM_PREP_CYCLES
) (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// object access from the network master
	input wire logic [15:0] obj_index,
	input wire logic obj_wr,
	input wire logic [15:0] obj_wdata,
	input wire logic obj_rd,
	output logic obj_wr_ok,
	output logic obj_wr_err,
	output logic obj_rvalid,
	output logic [15:0] obj_rdata,
	// local conditions
	input wire logic init_done,
	input wire logic net_operational,
	input wire logic main_power_ok,
	input wire logic power_removal_active,
	input wire logic motor_release_in,
	input wire logic torque_off_monitor_output,
	input wire logic test_op_active,
	input wire logic alarm_in,
	input wire logic motor_moving,
	input wire logic [15:0] qstop_option_code,
	// motion gating
	input wire logic motion_cmd,
	output logic motion_cmd_go,
	// drive outputs
	output logic motor_energise,
	output logic param_write_allowed,
	output logic operation_ready_output,
	output logic [15:0] status_word,
	output logic [7:0] alarm_code,
	output logic [7:0] drive_state
);
	typedef struct packed {
		dsm_state_t st;
		logic net_alarm;
		logic motor;
		logic param_ok;
		logic [15:0] cmd;
		logic [15:0] status;
		logic [7:0] alarm_code;
		logic rvalid;
		logic [15:0] rdata;
		logic wr_ok;
		logic wr_err;
	} dsm_regs_t;

	dsm_regs_t q, d;
	logic c_shut, c_on, c_enop, c_dv, c_qs, c_frst;
	logic prep_done, drop, can_on, net_fault, alarm_any, qso_stop;

	dsm_cmd_decode u_dec (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.cmd_word(q.cmd),
		.cmd_shutdown(c_shut),
		.cmd_switch_on(c_on),
		.cmd_enable_op(c_enop),
		.cmd_disable_voltage(c_dv),
		.cmd_quick_stop(c_qs),
		.fault_reset_pulse(c_frst)
	);

	dsm_prep_timer #(.CYCLES(PREP_CYCLES)) u_prep (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.run(q.st == DSM_OP_ENABLED),
		.done(prep_done)
	);

	// local condition terms
	assign drop = !net_operational || !main_power_ok
		|| power_removal_active || motor_release_in;
	assign can_on = net_operational && main_power_ok && !motor_release_in
		&& !torque_off_monitor_output && !test_op_active; // [RULE10]
	assign net_fault = !net_operational && motor_moving
		&& (q.st == DSM_OP_ENABLED || q.st == DSM_QUICK_STOP); // [RULE18]
	assign alarm_any = alarm_in || q.net_alarm;
	assign qso_stop = $signed(qstop_option_code) >= DSM_QSO_MIN
		&& $signed(qstop_option_code) <= DSM_QSO_MAX;

	// outputs
	assign motor_energise = q.motor;
	assign param_write_allowed = q.param_ok;
	assign operation_ready_output = prep_done; // [RULE6]
	// motion is held off until preparation completes
	// ready lags one cycle on leaving, so the state gates it too
	assign motion_cmd_go = motion_cmd && prep_done
		&& q.st == DSM_OP_ENABLED; // [RULE6]
	assign status_word = q.status;
	assign alarm_code = q.alarm_code;
	assign drive_state = q.st;
	assign obj_wr_ok = q.wr_ok;
	assign obj_wr_err = q.wr_err;
	assign obj_rvalid = q.rvalid;
	assign obj_rdata = q.rdata;

	// next state: object access, then transitions, then outputs
	always_comb begin
		d = q;
		d.wr_ok = 1'b0;
		d.wr_err = 1'b0;
		d.rvalid = 1'b0;
		// command word is the only steering path
		if (obj_wr) begin
			if (obj_index == DSM_CMD_WORD_IDX) begin
				d.cmd = obj_wdata; // [RULE1]
				d.wr_ok = 1'b1;
			end else if (obj_index == DSM_STATUS_WORD_IDX || !q.param_ok) begin
				d.wr_err = 1'b1; // [RULE2]
			end else begin
				d.wr_ok = 1'b1; // [RULE3]
			end
		end
		if (obj_rd) begin
			d.rvalid = 1'b1;
			if (obj_index == DSM_CMD_WORD_IDX) begin
				d.rdata = q.cmd;
			end else if (obj_index == DSM_STATUS_WORD_IDX) begin
				d.rdata = q.status; // [RULE1]
			end else begin
				d.rdata = '0;
			end
		end
		if (net_fault) begin
			d.net_alarm = 1'b1; // [RULE18]
		end
		// unmatched patterns fall through with no change [RULE19]
		unique case (q.st)
			DSM_NOT_READY: begin
				if (init_done) begin
					d.st = DSM_ON_DISABLED; // [RULE12]
				end
			end
			DSM_ON_DISABLED: begin
				if (alarm_any) begin
					d.st = DSM_FAULT_REACT; // [RULE14]
				end else if (c_shut) begin
					d.st = DSM_READY; // [RULE8]
				end
			end
			DSM_READY: begin
				if (alarm_any) begin
					d.st = DSM_FAULT_REACT; // [RULE14]
				end else if (c_dv || c_qs) begin
					d.st = DSM_ON_DISABLED; // [RULE8]
				end else if (c_on && can_on) begin
					d.st = DSM_SWITCHED_ON; // [RULE10]
				end else if (c_enop && can_on) begin
					d.st = DSM_OP_ENABLED; // [RULE9]
				end
			end
			DSM_SWITCHED_ON: begin
				if (alarm_any) begin
					d.st = DSM_FAULT_REACT; // [RULE14]
				end else if (c_dv || c_qs) begin
					d.st = DSM_ON_DISABLED; // [RULE8]
				end else if (c_shut || (!motor_moving && drop)) begin
					d.st = DSM_READY; // [RULE15]
				end else if (c_enop) begin
					d.st = DSM_OP_ENABLED; // [RULE9]
				end
			end
			DSM_OP_ENABLED: begin
				if (alarm_any || net_fault) begin
					d.st = DSM_FAULT_REACT; // [RULE14]
				end else if (c_dv) begin
					d.st = DSM_ON_DISABLED; // [RULE8]
				end else if (c_qs) begin
					d.st = DSM_QUICK_STOP; // [RULE8]
				end else if (c_shut || (!motor_moving && drop)) begin
					d.st = DSM_READY; // [RULE16]
				end else if (c_on) begin
					d.st = DSM_SWITCHED_ON; // [RULE9]
				end
			end
			DSM_QUICK_STOP: begin
				if (alarm_any || net_fault) begin
					d.st = DSM_FAULT_REACT; // [RULE14]
				end else if (c_dv || (qso_stop && !motor_moving)) begin
					d.st = DSM_ON_DISABLED; // [RULE13]
				end else if (c_enop) begin
					d.st = DSM_OP_ENABLED; // [RULE9]
				end
			end
			DSM_FAULT_REACT: begin
				// keep torque until the axis has stopped
				if (!motor_moving) begin
					d.st = DSM_FAULT; // [RULE14]
				end
			end
			DSM_FAULT: begin
				if (c_frst && !alarm_in) begin
					d.st = DSM_ON_DISABLED; // [RULE20]
					d.net_alarm = 1'b0;
				end
			end
			default: begin
				// illegal code: restart as from power-up
				d.st = DSM_NOT_READY;
			end
		endcase
		// outputs follow the next state so they align with it
		d.motor = d.st inside {DSM_OP_ENABLED, DSM_QUICK_STOP,
			DSM_FAULT_REACT}; // [RULE4] [RULE5]
		d.param_ok = d.st != DSM_NOT_READY; // [RULE2] [RULE5]
		d.alarm_code = d.net_alarm ? DSM_NET_ALARM_CODE
			: DSM_NO_ALARM_CODE; // [RULE18]
		d.status = DSM_STATUS_WORD_RST;
		if (d.st != DSM_NOT_READY) begin
			d.status[DSM_SW_VOLTAGE] = main_power_ok;
		end
		// state encoding of the low status bits
		unique case (d.st)
			DSM_ON_DISABLED: begin
				d.status[DSM_SW_ON_DISABLED] = 1'b1; // [RULE17]
				d.status[DSM_SW_QUICK_STOP] = 1'b1;
			end
			DSM_READY: begin
				d.status[DSM_SW_QUICK_STOP] = 1'b1; // [RULE17]
				d.status[DSM_SW_READY] = 1'b1;
			end
			DSM_SWITCHED_ON: begin
				d.status[DSM_SW_QUICK_STOP] = 1'b1; // [RULE17]
				d.status[DSM_SW_SWITCHED_ON:DSM_SW_READY] = 2'h3;
			end
			DSM_OP_ENABLED, DSM_FAULT_REACT: begin
				d.status[DSM_SW_QUICK_STOP] = 1'b1; // [RULE17]
				d.status[DSM_SW_OP_ENABLED:DSM_SW_READY] = 3'h7;
				d.status[DSM_SW_FAULT] = d.st == DSM_FAULT_REACT;
			end
			DSM_QUICK_STOP: begin
				d.status[DSM_SW_OP_ENABLED:DSM_SW_READY] = 3'h7; // [RULE17]
			end
			DSM_FAULT: begin
				d.status[DSM_SW_QUICK_STOP] = 1'b1; // [RULE17]
				d.status[DSM_SW_FAULT] = 1'b1;
			end
			default: begin
				d.status[DSM_SW_VOLTAGE] = 1'b0;
			end
		endcase
	end

	// state register; power-up lands in not ready [RULE11]
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= DSM_NOT_READY;
			q.cmd <= DSM_CMD_WORD_RST;
			q.status <= DSM_STATUS_WORD_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_reacting;
		q.st == DSM_FAULT_REACT && motor_energise;
	endsequence
	sequence s_faulted;
		q.st == DSM_FAULT && !motor_energise;
	endsequence

	init_lock_a: assert property ( // [RULE2]
		q.st == DSM_NOT_READY |-> !motor_energise && !param_write_allowed)
		else $error("motor or writes enabled during initialisation");
	idle_off_a: assert property ( // [RULE3]
		q.st inside {DSM_ON_DISABLED, DSM_READY, DSM_SWITCHED_ON}
		|-> !motor_energise && param_write_allowed)
		else $error("idle state energised or refused writes");
	energised_a: assert property ( // [RULE4]
		q.st inside {DSM_OP_ENABLED, DSM_QUICK_STOP, DSM_FAULT_REACT}
		|-> motor_energise && param_write_allowed)
		else $error("active state not energised");
	fault_off_a: assert property ( // [RULE5]
		q.st == DSM_FAULT |-> !motor_energise && param_write_allowed)
		else $error("fault state energised or refused writes");
	init_adv_a: assert property ( // [RULE12]
		ce && q.st == DSM_NOT_READY && init_done |=> q.st == DSM_ON_DISABLED)
		else $error("init done did not advance the machine");
	on_block_a: assert property ( // [RULE10]
		ce && q.st == DSM_READY && !can_on
		|=> !(q.st inside {DSM_SWITCHED_ON, DSM_OP_ENABLED}))
		else $error("switched on with a blocking condition");
	alarm_path_a: assert property ( // [RULE14]
		ce && alarm_in && motor_moving && q.st == DSM_OP_ENABLED
		|=> s_reacting)
		else $error("alarm did not enter fault reaction");
	react_done_a: assert property ( // [RULE14]
		s_reacting ##0 (ce && !motor_moving) |=> s_faulted)
		else $error("fault reaction did not settle in fault");
	gate_motion_a: assert property ( // [RULE6]
		motion_cmd_go |-> q.st == DSM_OP_ENABLED && operation_ready_output)
		else $error("motion passed before preparation finished");
	status_enc_a: assert property ( // [RULE17]
		q.st == DSM_QUICK_STOP |-> status_word[6:5] == 2'h0
		&& status_word[2:0] == 3'h7)
		else $error("quick stop status bits wrong");
	net_alarm_a: assert property ( // [RULE18]
		ce && net_fault |=> alarm_code == DSM_NET_ALARM_CODE
		&& q.st == DSM_FAULT_REACT)
		else $error("network loss while moving raised no alarm");
	stop_drop_a: assert property ( // [RULE16]
		ce && q.st == DSM_OP_ENABLED && !motor_moving && drop && !alarm_any
		&& !c_dv && !c_qs |=> q.st == DSM_READY && !motor_energise)
		else $error("stopped drop condition did not reach ready");
	fault_clr_a: assert property ( // [RULE20]
		ce && q.st == DSM_FAULT && c_frst && !alarm_in
		|=> q.st == DSM_ON_DISABLED && alarm_code == DSM_NO_ALARM_CODE)
		else $error("fault reset did not clear the fault");
endmodule
`default_nettype wire

// File: dsm_master_model.sv
// fieldbus master model: object writes, reads and motion requests
`default_nettype none
module dsm_master_model (
	// clock
	input wire logic core_clk,
	// object access
	output logic [15:0] obj_index,
	output logic obj_wr,
	output logic [15:0] obj_wdata,
	output logic obj_rd,
	input wire logic obj_wr_ok,
	input wire logic obj_wr_err,
	input wire logic obj_rvalid,
	input wire logic [15:0] obj_rdata,
	// motion gating
	input wire logic operation_ready_output,
	output logic motion_cmd
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus at time zero
	initial begin
		obj_index = 16'h0000;
		obj_wr = 1'b0;
		obj_wdata = 16'h0000;
		obj_rd = 1'b0;
		motion_cmd = 1'b0;
	end

	// one write pulse; released lines flip so stale data never matches
	task automatic wr(input logic [15:0] idx, input logic [15:0] d,
		output logic ok, output logic err);
		@(posedge core_clk);
		obj_wr <= 1'b1;
		obj_index <= idx;
		obj_wdata <= d;
		@(posedge core_clk);
		obj_wr <= 1'b0;
		obj_index <= ~idx;
		obj_wdata <= ~d;
		#1;
		ok = obj_wr_ok;
		err = obj_wr_err;
	endtask

	// one read pulse; answer is registered one edge later
	task automatic rd(input logic [15:0] idx, output logic rv,
		output logic [15:0] d);
		@(posedge core_clk);
		obj_rd <= 1'b1;
		obj_index <= idx;
		@(posedge core_clk);
		obj_rd <= 1'b0;
		obj_index <= ~idx;
		#1;
		rv = obj_rvalid;
		d = obj_rdata;
	endtask

	// motion waits for ready unless a scenario asks for an early one
	task automatic motion(input logic on, input logic early);
		int n;
		n = 0;
		while (on && !early && operation_ready_output !== 1'b1
			&& n < 1000) begin
			@(posedge core_clk);
			n++;
		end
		@(posedge core_clk);
		motion_cmd <= on;
	endtask
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the drive state machine
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	mismatches++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
	import dsm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned PREP = 20;
	localparam int LIMIT = 4000;
	logic core_clk, rst_n, ce, obj_wr, obj_rd, obj_wr_ok, obj_wr_err;
	logic [15:0] obj_index, obj_wdata, obj_rdata, qstop_option_code;
	logic obj_rvalid, init_done, net_operational, main_power_ok;
	logic power_removal_active, motor_release_in, test_op_active;
	logic torque_off_monitor_output, alarm_in, motor_moving, motion_cmd;
	logic motion_cmd_go, motor_energise, param_write_allowed;
	logic operation_ready_output;
	logic [15:0] status_word;
	logic [7:0] alarm_code, drive_state;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;

	dsm_top #(.PREP_CYCLES(PREP)) dsm_top_i (.core_clk, .rst_n, .ce,
		.obj_index, .obj_wr, .obj_wdata, .obj_rd, .obj_wr_ok,
		.obj_wr_err, .obj_rvalid, .obj_rdata, .init_done,
		.net_operational, .main_power_ok, .power_removal_active,
		.motor_release_in, .torque_off_monitor_output, .test_op_active,
		.alarm_in, .motor_moving, .qstop_option_code, .motion_cmd,
		.motion_cmd_go, .motor_energise, .param_write_allowed,
		.operation_ready_output, .status_word, .alarm_code,
		.drive_state);

	dsm_master_model dsm_master_model_i (.core_clk, .obj_index, .obj_wr,
		.obj_wdata, .obj_rd, .obj_wr_ok, .obj_wr_err, .obj_rvalid,
		.obj_rdata, .operation_ready_output, .motion_cmd);

	// 10 MHz clock
	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	// hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (mismatches == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// expected low status bits; voltage bit follows main power
	function automatic logic [15:0] sw_of(input dsm_state_t s);
		logic [15:0] v;
		case (s)
			DSM_ON_DISABLED: v = 16'h0060;
			DSM_READY: v = 16'h0021;
			DSM_SWITCHED_ON: v = 16'h0023;
			DSM_OP_ENABLED: v = 16'h0027;
			DSM_QUICK_STOP: v = 16'h0007;
			DSM_FAULT_REACT: v = 16'h002F;
			DSM_FAULT: v = 16'h0028;
			default: v = 16'h0000;
		endcase
		if (s != DSM_NOT_READY) v[4] = main_power_ok;
		return v;
	endfunction

	// bounded wait for a state, then state, status, motor, writes
	task automatic expect_state(input dsm_state_t s);
		logic [15:0] e;
		e = sw_of(s);
		for (int i = 0; i < 12 && drive_state !== s; i++) begin
			@(posedge core_clk);
			#1;
		end
		`CHK("drive_state", s, drive_state)
		`CHK("status_word", e[6:0], status_word[6:0])
		`CHK("motor_energise", (s == DSM_OP_ENABLED ||
			s == DSM_QUICK_STOP || s == DSM_FAULT_REACT),
			motor_energise)
		`CHK("param_write_allowed", (s != DSM_NOT_READY),
			param_write_allowed)
	endtask

	// state must not move for a few cycles
	task automatic hold_state(input dsm_state_t s);
		repeat (3) @(posedge core_clk);
		#1;
		`CHK("drive_state_held", s, drive_state)
	endtask

	task automatic cw(input logic [15:0] d);
		logic ok, err;
		dsm_master_model_i.wr(DSM_CMD_WORD_IDX, d, ok, err);
		`CHK("cmd_wr_ok", 1'b1, ok)
	endtask

	// bad[4:0] break switch-on conditions, bad[5] is power removal
	task automatic set_cond(input logic [5:0] bad);
		@(posedge core_clk);
		net_operational <= ~bad[0];
		main_power_ok <= ~bad[1];
		motor_release_in <= bad[2];
		torque_off_monitor_output <= bad[3];
		test_op_active <= bad[4];
		power_removal_active <= bad[5];
	endtask

	task automatic set_ma(input logic mv, input logic al);
		@(posedge core_clk);
		motor_moving <= mv;
		alarm_in <= al;
	endtask

	// main sequence
	initial begin
		logic ok, err, rv;
		logic [15:0] d;
		rst_n = 1'b0;
		ce = 1'b1;
		init_done = 1'b0;
		{net_operational, main_power_ok} = 2'h3;
		{power_removal_active, motor_release_in} = 2'h0;
		{torque_off_monitor_output, test_op_active} = 2'h0;
		{alarm_in, motor_moving} = 2'h0;
		qstop_option_code = 16'h0002;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		expect_state(DSM_NOT_READY);
		dsm_master_model_i.wr(16'h2000, 16'h1234, ok, err);
		`CHK("param_wr_err", 1'b1, err)
		@(posedge core_clk);
		init_done <= 1'b1;
		expect_state(DSM_ON_DISABLED);
		dsm_master_model_i.wr(16'h2000, 16'h1234, ok, err);
		`CHK("param_wr_ok", 1'b1, ok)
		dsm_master_model_i.wr(DSM_STATUS_WORD_IDX, 16'h0000, ok, err);
		`CHK("status_wr_err", 1'b1, err)
		dsm_master_model_i.rd(DSM_STATUS_WORD_IDX, rv, d);
		`CHK("status_read", 7'h70, d[6:0])
		cw(16'h000F);
		hold_state(DSM_ON_DISABLED);
		cw(16'h0006);
		expect_state(DSM_READY);
		for (int k = 0; k < 5; k++) begin
			set_cond(6'h01 << k);
			cw(16'h000F);
			hold_state(DSM_READY);
			cw(16'h0006);
			set_cond(6'h00);
		end
		cw(16'h0007);
		expect_state(DSM_SWITCHED_ON);
		set_cond(6'h04);
		expect_state(DSM_READY);
		set_cond(6'h00);
		expect_state(DSM_SWITCHED_ON);
		cw(16'h000F);
		expect_state(DSM_OP_ENABLED);
		cw(16'h0007);
		expect_state(DSM_SWITCHED_ON);
		cw(16'h0006);
		cw(16'h000F);
		expect_state(DSM_OP_ENABLED);
		dsm_master_model_i.motion(1'b1, 1'b1);
		#1;
		`CHK("motion_go_early", 1'b0, motion_cmd_go)
		repeat (PREP - 6) @(posedge core_clk);
		#1;
		`CHK("ready_early", 1'b0, operation_ready_output)
		repeat (8) @(posedge core_clk);
		#1;
		`CHK("ready_late", 1'b1, operation_ready_output)
		`CHK("motion_go", 1'b1, motion_cmd_go)
		dsm_master_model_i.motion(1'b0, 1'b1);
		set_cond(6'h20);
		expect_state(DSM_READY);
		set_cond(6'h00);
		expect_state(DSM_OP_ENABLED);
		// quick stop with option codes 0 to 3, 0 staying put
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			qstop_option_code <= 16'(k);
			cw(16'h0006);
			cw(16'h000F);
			expect_state(DSM_OP_ENABLED);
			set_ma(1'b1, 1'b0);
			cw(16'h0002);
			expect_state(DSM_QUICK_STOP);
			`CHK("ready_qs", 1'b0, operation_ready_output)
			set_ma(1'b0, 1'b0);
			if (k == 0) begin
				hold_state(DSM_QUICK_STOP);
				cw(16'h0000);
			end
			expect_state(DSM_ON_DISABLED);
		end
		cw(16'h0006);
		cw(16'h000F);
		expect_state(DSM_OP_ENABLED);
		set_ma(1'b1, 1'b1);
		expect_state(DSM_FAULT_REACT);
		set_ma(1'b0, 1'b1);
		expect_state(DSM_FAULT);
		dsm_master_model_i.wr(16'h2000, 16'h5A5A, ok, err);
		`CHK("param_wr_fault", 1'b1, ok)
		cw(16'h0000);
		cw(16'h0080);
		hold_state(DSM_FAULT);
		set_ma(1'b0, 1'b0);
		cw(16'h0000);
		cw(16'h0080);
		expect_state(DSM_ON_DISABLED);
		cw(16'h0006);
		cw(16'h000F);
		expect_state(DSM_OP_ENABLED);
		set_ma(1'b1, 1'b0);
		set_cond(6'h01);
		expect_state(DSM_FAULT_REACT);
		`CHK("alarm_code", DSM_NET_ALARM_CODE, alarm_code)
		set_ma(1'b0, 1'b0);
		set_cond(6'h00);
		expect_state(DSM_FAULT);
		cw(16'h0000);
		cw(16'h0080);
		expect_state(DSM_ON_DISABLED);
		`CHK("alarm_clear", DSM_NO_ALARM_CODE, alarm_code)
		// clock enable low: the write is not taken and nothing moves
		@(posedge core_clk);
		ce <= 1'b0;
		dsm_master_model_i.wr(DSM_CMD_WORD_IDX, 16'h0006, ok, err);
		`CHK("frozen_wr_ok", 1'b0, ok)
		hold_state(DSM_ON_DISABLED);
		@(posedge core_clk);
		ce <= 1'b1;
		hold_state(DSM_ON_DISABLED);
		cw(16'h0006);
		expect_state(DSM_READY);
		give_verdict();
	end
endmodule
`default_nettype wire
